//--- verilog/bsc_commutator.v
`timescale 1ns/1ps
`include "bsc_map.vh"

module bsc_commutator (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // Drive inhibit pin, asynchronous
  input  wire        drive_inhibit,
  // Axis 1 rotor position tracks, asynchronous
  input  wire [2:0]  axis1_position,
  // Axis 2 rotor position tracks, asynchronous
  input  wire [2:0]  axis2_position,
  // Duty words, same clock domain
  input  wire [11:0] axis1_duty,
  input  wire [11:0] axis2_duty,
  // Axis 1 gates
  output wire        axis1_phasea_upper_gate,
  output wire        axis1_phasea_lower_gate,
  output wire        axis1_phaseb_upper_gate,
  output wire        axis1_phaseb_lower_gate,
  output wire        axis1_phasec_upper_gate,
  output wire        axis1_phasec_lower_gate,
  // Axis 2 gates
  output wire        axis2_phasea_upper_gate,
  output wire        axis2_phasea_lower_gate,
  output wire        axis2_phaseb_upper_gate,
  output wire        axis2_phaseb_lower_gate,
  output wire        axis2_phasec_upper_gate,
  output wire        axis2_phasec_lower_gate,
  // Active sector per axis, for monitoring
  output wire [2:0]  axis1_sector,
  output wire [2:0]  axis2_sector
);

  // Last count of a chopping period
  localparam [11:0] PWM_LAST = `BSC_PWM_LAST;

  // Reset synchroniser: asserts at once, releases on a clock edge,
  // so no flop sees the release inside its recovery window
  reg rst_meta;
  reg rst_sync;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst_sync <= rst_meta;
    end
  end

  // Inhibit synchroniser; first stage feeds only the second
  reg inh_meta;
  reg inh_sync;
  always @(posedge clk_sys or posedge rst_sync) begin
    if (rst_sync) begin
      inh_meta <= 1'b1;
      inh_sync <= 1'b1;
    end else begin
      inh_meta <= drive_inhibit;
      inh_sync <= inh_meta;
    end
  end

  // Shared chopping counter, 2500 cycles gives 16 kHz
  reg  [11:0] pwm_cnt;
  wire        pwm_wrap = (pwm_cnt == PWM_LAST);
  always @(posedge clk_sys or posedge rst_sync) begin
    if (rst_sync) begin
      pwm_cnt <= 12'h000;
    end else if (pwm_wrap) begin
      pwm_cnt <= 12'h000;
    end else begin
      pwm_cnt <= pwm_cnt + 12'h001;
    end
  end

  // Per-axis inputs and results packed for the generate loop
  wire [5:0]  pos_flat  = {axis2_position, axis1_position};
  wire [23:0] duty_flat = {axis2_duty, axis1_duty};
  wire [11:0] gate_flat;
  wire [5:0]  sec_flat;

  // One identical commutator per axis
  genvar ax;
  generate
    for (ax = 0; ax < 2; ax = ax + 1) begin : g_axis
      reg  [2:0]  pos_meta;
      reg  [2:0]  pos_sync;
      reg  [2:0]  pos_prev;
      reg  [2:0]  sector;
      reg  [11:0] duty;
      reg  [5:0]  gates;
      reg  [5:0]  next_gates;
      reg  [5:0]  pattern;
      wire        chop_on = (pwm_cnt < duty);
      wire        pos_steady = (pos_sync == pos_prev);

      // Position synchroniser and one more sample; several code bits may
      // move at once, so a code counts only when two samples agree
      always @(posedge clk_sys or posedge rst_sync) begin
        if (rst_sync) begin
          pos_meta <= 3'h0;
          pos_sync <= 3'h0;
          pos_prev <= 3'h0;
        end else begin
          pos_meta <= pos_flat[ax*3 +: 3];
          pos_sync <= pos_meta;
          pos_prev <= pos_sync;
        end
      end

      // Sector and duty move only at a chopping period boundary,
      // so a position glitch cannot cut a pulse short
      always @(posedge clk_sys or posedge rst_sync) begin
        if (rst_sync) begin
          sector <= `BSC_SEC_0;
          duty   <= `BSC_DUTY_RST;
        end else if (pwm_wrap) begin
          duty <= duty_flat[ax*12 +: 12];
          if (pos_steady && (pos_sync <= `BSC_SEC_5)) begin
            sector <= pos_sync;
          end
        end
      end

      // Commutation table; invalid codes 6 and 7 hold the old sector
      always @* begin
        pattern = 6'h00;
        case (sector)
          `BSC_SEC_0: begin
            pattern[`BSC_AL] = 1'b1;
            pattern[`BSC_BH] = 1'b1;
          end
          `BSC_SEC_1: begin
            pattern[`BSC_AL] = 1'b1;
            pattern[`BSC_CH] = 1'b1;
          end
          `BSC_SEC_2: begin
            pattern[`BSC_BL] = 1'b1;
            pattern[`BSC_CH] = 1'b1;
          end
          `BSC_SEC_3: begin
            pattern[`BSC_AH] = 1'b1;
            pattern[`BSC_BL] = 1'b1;
          end
          `BSC_SEC_4: begin
            pattern[`BSC_AH] = 1'b1;
            pattern[`BSC_CL] = 1'b1;
          end
          `BSC_SEC_5: begin
            pattern[`BSC_BH] = 1'b1;
            pattern[`BSC_CL] = 1'b1;
          end
          default: begin
            pattern = 6'h00;
          end
        endcase
      end

      // Chop, inhibit, and a final shoot-through guard per leg
      always @* begin
        next_gates = pattern & {6{chop_on & ~inh_sync}};
        if (next_gates[`BSC_AH] & next_gates[`BSC_AL]) begin
          next_gates[`BSC_AH] = 1'b0;
          next_gates[`BSC_AL] = 1'b0;
        end
        if (next_gates[`BSC_BH] & next_gates[`BSC_BL]) begin
          next_gates[`BSC_BH] = 1'b0;
          next_gates[`BSC_BL] = 1'b0;
        end
        if (next_gates[`BSC_CH] & next_gates[`BSC_CL]) begin
          next_gates[`BSC_CH] = 1'b0;
          next_gates[`BSC_CL] = 1'b0;
        end
      end

      // Registered gates keep the pins free of decode glitches
      always @(posedge clk_sys or posedge rst_sync) begin
        if (rst_sync) begin
          gates <= 6'h00;
        end else begin
          gates <= next_gates;
        end
      end

      // Hand this axis's gates and sector to the flat buses
      assign gate_flat[ax*6 +: 6] = gates;
      assign sec_flat[ax*3 +: 3]  = sector;
    end
  endgenerate

  // Axis 1 gate pins
  assign axis1_phasea_upper_gate = gate_flat[`BSC_AH];
  assign axis1_phasea_lower_gate = gate_flat[`BSC_AL];
  assign axis1_phaseb_upper_gate = gate_flat[`BSC_BH];
  assign axis1_phaseb_lower_gate = gate_flat[`BSC_BL];
  assign axis1_phasec_upper_gate = gate_flat[`BSC_CH];
  assign axis1_phasec_lower_gate = gate_flat[`BSC_CL];

  // Axis 2 gate pins
  assign axis2_phasea_upper_gate = gate_flat[6 + `BSC_AH];
  assign axis2_phasea_lower_gate = gate_flat[6 + `BSC_AL];
  assign axis2_phaseb_upper_gate = gate_flat[6 + `BSC_BH];
  assign axis2_phaseb_lower_gate = gate_flat[6 + `BSC_BL];
  assign axis2_phasec_upper_gate = gate_flat[6 + `BSC_CH];
  assign axis2_phasec_lower_gate = gate_flat[6 + `BSC_CL];

  // Sector monitors
  assign axis1_sector            = sec_flat[2:0];
  assign axis2_sector            = sec_flat[5:3];

endmodule // bsc_commutator

//--- verilog/bsc_map.vh
`ifndef BSC_MAP_VH
`define BSC_MAP_VH
// System clock rate in Hz
`define BSC_CLK_HZ        40000000
// Gate chopping rate in Hz
`define BSC_PWM_HZ        16000
// Cycles per chopping period, rounded down
`define BSC_PWM_PERIOD    (`BSC_CLK_HZ / `BSC_PWM_HZ)
// Last count of a chopping period, period minus one
`define BSC_PWM_LAST      12'h9c3
// Width of the chopping counter and duty input
`define BSC_PWM_W         12
// Reset value of the duty word
`define BSC_DUTY_RST      12'h000
// Sector codes, one per 60 degree step
`define BSC_SEC_0         3'h0
`define BSC_SEC_1         3'h1
`define BSC_SEC_2         3'h2
`define BSC_SEC_3         3'h3
`define BSC_SEC_4         3'h4
`define BSC_SEC_5         3'h5
// Gate vector bit positions
`define BSC_AH            0
`define BSC_AL            1
`define BSC_BH            2
`define BSC_BL            3
`define BSC_CH            4
`define BSC_CL            5
`endif

//--- test/bsc_commutator_props.sv
`timescale 1ns/1ps
module bsc_chk (
  // Clock, reset and inhibit pin
  input wire       clk_sys, sys_rst, drive_inhibit,
  // Gate commands
  input wire       axis1_phasea_upper_gate, axis1_phasea_lower_gate,
  input wire       axis1_phaseb_upper_gate, axis1_phaseb_lower_gate,
  input wire       axis1_phasec_upper_gate, axis1_phasec_lower_gate,
  input wire       axis2_phasea_upper_gate, axis2_phasea_lower_gate,
  input wire       axis2_phaseb_upper_gate, axis2_phaseb_lower_gate,
  input wire       axis2_phasec_upper_gate, axis2_phasec_lower_gate,
  // Active sectors
  input wire [2:0] axis1_sector, axis2_sector
);
  // Allowed gate set per sector, sector 0 in the low bits
  localparam [35:0] pat = 36'h921258486;
  wire [5:0] g1 = {axis1_phasec_lower_gate, axis1_phasec_upper_gate,
    axis1_phaseb_lower_gate, axis1_phaseb_upper_gate,
    axis1_phasea_lower_gate, axis1_phasea_upper_gate};
  wire [5:0] g2 = {axis2_phasec_lower_gate, axis2_phasec_upper_gate,
    axis2_phaseb_lower_gate, axis2_phaseb_upper_gate,
    axis2_phasea_lower_gate, axis2_phasea_upper_gate};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Pin held long enough to pass the synchroniser
  sequence inh_held; drive_inhibit [*3]; endsequence
  shoot_free1_a: assert property (!(g1[0]&g1[1] | g1[2]&g1[3] | g1[4]&g1[5]))
    else $error("axis1 leg both on");
  shoot_free2_a: assert property (!(g2[0]&g2[1] | g2[2]&g2[3] | g2[4]&g2[5]))
    else $error("axis2 leg both on");
  pattern_one_a: assert property ($stable(axis1_sector) && |g1 |->
    g1 == pat[axis1_sector*6 +: 6]) else $error("axis1 gate set");
  pattern_two_a: assert property ($stable(axis2_sector) && |g2 |->
    g2 == pat[axis2_sector*6 +: 6]) else $error("axis2 gate set");
  inhibit_off_a: assert property (inh_held |=> !(|{g1, g2}))
    else $error("gates on under inhibit");
  sector_range_a: assert property (axis1_sector < 3'h6 && axis2_sector < 3'h6)
    else $error("sector out of range");
  sector_hold1_a: assert property ($changed(axis1_sector) |=>
    $stable(axis1_sector) [*8]) else $error("axis1 sector jitter");
  sector_hold2_a: assert property ($changed(axis2_sector) |=>
    $stable(axis2_sector) [*8]) else $error("axis2 sector jitter");
endmodule // bsc_chk
bind bsc_commutator bsc_chk u_chk (.*);

//--- test/bsc_bridge_model.sv
`timescale 1ns/1ps
// Gate driver and FET bridge of one axis
module bsc_bridge_model (
  // Shutdown pin and gate commands
  input  wire       drive_inhibit,
  input  wire [5:0] gate,
  // Leg sourcing and sinking, phase A in bit 0
  output wire [2:0] src,
  output wire [2:0] snk
);
  // Shutdown disables every driver output
  wire [2:0] hi = drive_inhibit ? 3'h0 : {gate[4], gate[2], gate[0]};
  wire [2:0] lo = drive_inhibit ? 3'h0 : {gate[5], gate[3], gate[1]};
  // Own shoot-through guard, a leg with both on conducts neither way
  assign src = hi & ~lo;
  assign snk = lo & ~hi;
endmodule // bsc_bridge_model

//--- test/test_bsc_commutator.sv
`timescale 1ns/1ps
module test_bsc_commutator;
  logic       clk_sys = 0, sys_rst = 1, drive_inhibit = 0;
  logic [2:0] p1 = 3'h0, p2 = 3'h3;
  logic [11:0] d1 = 12'h3e8, d2 = 12'h9c4;
  wire  [2:0] s1, s2, src1, snk1, src2, snk2;
  wire  [5:0] g1, g2;
  int         failures = 0, n_tests = 0, cyc = 0, k, j;
  // Expected {sink, source} legs, row index is the position code
  logic [5:0] rows [6] = '{6'h0a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22};
  bsc_commutator u_dut (.clk_sys, .sys_rst, .drive_inhibit,
    .axis1_position(p1), .axis2_position(p2),
    .axis1_duty(d1), .axis2_duty(d2),
    .axis1_phasea_upper_gate(g1[0]), .axis1_phasea_lower_gate(g1[1]),
    .axis1_phaseb_upper_gate(g1[2]), .axis1_phaseb_lower_gate(g1[3]),
    .axis1_phasec_upper_gate(g1[4]), .axis1_phasec_lower_gate(g1[5]),
    .axis2_phasea_upper_gate(g2[0]), .axis2_phasea_lower_gate(g2[1]),
    .axis2_phaseb_upper_gate(g2[2]), .axis2_phaseb_lower_gate(g2[3]),
    .axis2_phasec_upper_gate(g2[4]), .axis2_phasec_lower_gate(g2[5]),
    .axis1_sector(s1), .axis2_sector(s2));
  bsc_bridge_model u_br1 (.drive_inhibit, .gate(g1), .src(src1), .snk(snk1));
  bsc_bridge_model u_br2 (.drive_inhibit, .gate(g2), .src(src2), .snk(snk2));
  // 40 MHz clock
  initial forever #12.5 clk_sys = ~clk_sys;
  task chk(input string what, input logic [11:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task test_done;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // First gate-on cycle of a period in sector e, bounded by 5200 cycles, just over two periods
  task wait_on(input [2:0] e);
    k = 0;
    while (!(s1 === e && |g1) && k < 5200) begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  // Hang guard, the run needs about eight periods of 2500 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    sys_rst = 0;
    // Full clockwise turn, axis 2 half a turn ahead
    for (int i = 0; i < 6; i++) begin
      j = (i + 3) % 6;
      p1 = i[2:0];
      p2 = j[2:0];
      wait_on(i[2:0]);
      chk("sector2", j[11:0], s2);
      chk("axis1 legs", rows[i], {snk1, src1});
      chk("axis2 legs", rows[j], {snk2, src2});
      k = 0;
      while (|g1 && k < 3000) begin
        @(negedge clk_sys);
        k++;
      end
      chk("on time", 12'h3e8, k[11:0]);
    end
    // Invalid code must leave the sector alone
    p1 = 3'h7;
    wait_on(3'h5);
    chk("hold", 12'h005, s1);
    // Inhibit in mid pulse
    drive_inhibit = 1;
    repeat (4) @(negedge clk_sys);
    chk("inhibit", 12'h000, {g2, g1});
    drive_inhibit = 0;
    // Reset in mid run, restart in sector 2 with axis 2 at zero duty
    sys_rst = 1;
    p1 = 3'h2;
    d2 = 12'h000;
    @(negedge clk_sys);
    chk("reset", 12'h000, {s2, s1, g1});
    chk("reset axis2", 12'h000, g2);
    sys_rst = 0;
    repeat (2) begin
      @(negedge clk_sys);
      chk("after reset", 12'h000, {g2, g1});
    end
    wait_on(3'h2);
    chk("restart", 12'h002, s1);
    chk("restart legs", rows[2], {snk1, src1});
    chk("zero duty", 12'h000, g2);
    test_done;
  end
endmodule // test_bsc_commutator
